// File: include/arcd_map.svh
`ifndef ARCD_MAP_SVH
`define ARCD_MAP_SVH

// Register indices; byte address is four times the index
`define ARCD_IDX_RESULT_LOW 8'hC2
`define ARCD_IDX_RESULT_HIGH 8'hC3
`define ARCD_IDX_CMP_LOW 8'hCE
`define ARCD_IDX_CMP_HIGH 8'hCF
`define ARCD_IDX_CMP_BRAKE_CTRL 8'hE2
`define ARCD_IDX_TRIG_DELAY_LOW 8'hE3
`define ARCD_IDX_PIN_DISCONNECT 8'hF6
`define ARCD_IDX_CONV_CTRL 8'hE8
`define ARCD_IDX_IRQ_STATUS 8'hEA
`define ARCD_IDX_IRQ_MASK 8'hEB

// Reset values
`define ARCD_RST_BYTE 8'h00
`define ARCD_RST_CMP 12'h000
`define ARCD_RST_DELAY 9'h000

// Comparator and brake control fields
`define ARCD_CBC_BRAKE_EN 7
`define ARCD_CBC_POLARITY 6
`define ARCD_CBC_CMP_EN 5
`define ARCD_CBC_CMP_OUT 4
`define ARCD_CBC_DELAY_B8 0

// Conversion control fields
`define ARCD_CC_EXT_TRIG_EN 0
`define ARCD_CC_START_BUSY 1
`define ARCD_CC_DONE_FLAG 2

// Interrupt status and mask fields
`define ARCD_IRQ_DONE 0
`define ARCD_IRQ_BRAKE 1

// Widths
`define ARCD_RESULT_W 12
`define ARCD_DELAY_W 9
`define ARCD_PIN_W 8
`define ARCD_ADDR_W 12

`endif

// File: include/arcd_pkg.sv
package arcd_pkg;

  // Conversion sequencing
  typedef enum logic [1:0] {
    ARCD_IDLE,
    ARCD_DELAY,
    ARCD_CONV
  } arcd_state_t;

  // Answer from the analog converter core
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } arcd_adc_rsp_t;

  // Requests toward the PWM unit
  typedef struct packed {
    logic brake;
    logic run_clr;
  } arcd_pwm_req_t;

endpackage

// File: design/arcd_trig_delay.sv
`timescale 1ns/1ps
`include "arcd_map.svh"

module arcd_trig_delay (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic abort,
  input wire logic [`ARCD_DELAY_W-1:0] delay,
  output logic expire
);

  logic [`ARCD_DELAY_W-1:0] cnt_ff;
  logic [`ARCD_DELAY_W-1:0] nxt_cnt;
  logic active_ff;
  logic nxt_active;

  // Expires in the same cycle that the count reaches zero
  assign expire = active_ff && (cnt_ff == `ARCD_RST_DELAY);

  // Down counter, one step per pclk cycle
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_active = active_ff;
    if (abort) begin
      nxt_active = 1'b0;
    end else if (load) begin
      nxt_cnt = delay;
      nxt_active = 1'b1;
    end else if (expire) begin
      nxt_active = 1'b0;
    end else if (active_ff) begin
      nxt_cnt = cnt_ff - 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= `ARCD_RST_DELAY;
      active_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      active_ff <= nxt_active;
    end
  end

endmodule

// File: design/arcd_core.sv
// Behaviour
// - Compare output rising with brake enabled asserts PWM brake; disabled means none
// - Compare brake clears PWM run flag; software restarts PWM
// - Polarity 0: output 1 when result >= compare value
// - Polarity 1: output 1 when result < compare value
// - Comparator works only while its enable bit is 1
// - Comparator output updates at each conversion end, holds otherwise
// - Disconnect bit 1 forces pin digital read to 0
// - Delay is 9 bits: low byte register plus control bit 0
// - External trigger waits out the programmed delay before conversion
// - Result readable as high byte 11:4 and low nibble 3:0
// - Compare value held as high byte 11:4 and low nibble 3:0
// - Done flag set by hardware, cleared by software, blocks new starts
// - Start bit write 1 starts, reads 1 while busy, self clears
// - External triggers ignored while a conversion is busy
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "arcd_map.svh"

module arcd_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ARCD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trigger,
  input wire arcd_pkg::arcd_adc_rsp_t adc_rsp,
  output logic adc_start,
  output arcd_pkg::arcd_pwm_req_t pwm_req,
  input wire logic [`ARCD_PIN_W-1:0] pin_din,
  output logic [`ARCD_PIN_W-1:0] pin_dread,
  output logic irq
);

  // Byte address to register index, aligned words only
  function automatic logic [8:0] word_index(input logic [`ARCD_ADDR_W-1:0] addr);
    word_index = {(addr[1:0] != 2'h0) || (addr[11:10] != 2'h0), addr[9:2]};
  endfunction

  // Register index known to this block
  function automatic logic is_mapped(input logic [8:0] idx);
    case (idx)
      {1'b0, `ARCD_IDX_RESULT_LOW}, {1'b0, `ARCD_IDX_RESULT_HIGH},
      {1'b0, `ARCD_IDX_CMP_LOW}, {1'b0, `ARCD_IDX_CMP_HIGH},
      {1'b0, `ARCD_IDX_CMP_BRAKE_CTRL}, {1'b0, `ARCD_IDX_TRIG_DELAY_LOW},
      {1'b0, `ARCD_IDX_PIN_DISCONNECT}, {1'b0, `ARCD_IDX_CONV_CTRL},
      {1'b0, `ARCD_IDX_IRQ_STATUS}, {1'b0, `ARCD_IDX_IRQ_MASK}: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Result comparator with selectable polarity
  function automatic logic compare(input logic [11:0] res, input logic [11:0] ref_val,
                                   input logic pol);
    if (pol) begin
      compare = (res < ref_val);
    end else begin
      compare = (res >= ref_val);
    end
  endfunction

  // Register state
  logic [11:0] result_ff;
  logic [11:0] nxt_result;
  logic [11:0] cmp_value_ff;
  logic [11:0] nxt_cmp_value;
  logic brake_en_ff;
  logic nxt_brake_en;
  logic polarity_ff;
  logic nxt_polarity;
  logic cmp_en_ff;
  logic nxt_cmp_en;
  logic cmp_out_ff;
  logic nxt_cmp_out;
  logic [8:0] delay_ff;
  logic [8:0] nxt_delay;
  logic [7:0] disconnect_ff;
  logic [7:0] nxt_disconnect;
  logic ext_en_ff;
  logic nxt_ext_en;
  logic done_ff;
  logic nxt_done;
  logic [1:0] irq_stat_ff;
  logic [1:0] nxt_irq_stat;
  logic [1:0] irq_mask_ff;
  logic [1:0] nxt_irq_mask;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  arcd_pkg::arcd_state_t state_ff;
  arcd_pkg::arcd_state_t nxt_state;

  // Pin synchronisers and trigger edge detect
  logic trig_meta_ff;
  logic trig_sync_ff;
  logic trig_prev_ff;
  logic [7:0] pin_meta_ff;
  logic [7:0] pin_sync_ff;
  logic [7:0] pin_dread_ff;
  logic [7:0] nxt_pin_dread;
  logic brake_prev_ff;

  logic [8:0] idx;
  logic wr_en;
  logic rd_setup;
  logic sw_start;
  logic trig_edge;
  logic delay_load;
  logic delay_abort;
  logic delay_expire;
  logic conv_end;
  logic brake_lvl;
  logic brake_rise;
  logic [7:0] wbyte;

  // APB decode; writes land in the access phase only
  assign idx = word_index(paddr);
  assign wbyte = pwdata[7:0];
  assign wr_en = psel && penable && pwrite && is_mapped(idx);
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1; // Zero wait state: read data prepared in setup phase
  assign pslverr = psel && penable && !is_mapped(idx);
  assign prdata = rdata_ff;

  // Trigger pin: two flops, then rising edge
  assign trig_edge = trig_sync_ff && !trig_prev_ff;

  // Software start: write one only, ignored while busy or done flag set
  assign sw_start = wr_en && (idx == {1'b0, `ARCD_IDX_CONV_CTRL})
                    && wbyte[`ARCD_CC_START_BUSY];
  assign conv_end = (state_ff == arcd_pkg::ARCD_CONV) && adc_rsp.done;

  // Delay counter control
  assign delay_load = (state_ff == arcd_pkg::ARCD_IDLE) && !done_ff && !sw_start
                      && ext_en_ff && trig_edge;
  assign delay_abort = (state_ff == arcd_pkg::ARCD_CONV); // Counter held idle while converting
  assign adc_start = (state_ff == arcd_pkg::ARCD_DELAY && delay_expire)
                     || (state_ff == arcd_pkg::ARCD_IDLE && !done_ff && sw_start);

  arcd_trig_delay u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .load(delay_load),
    .abort(delay_abort),
    .delay(delay_ff),
    .expire(delay_expire)
  );

  // Conversion sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      arcd_pkg::ARCD_IDLE: begin
        if (adc_start) begin
          nxt_state = arcd_pkg::ARCD_CONV;
        end else if (delay_load) begin
          nxt_state = arcd_pkg::ARCD_DELAY;
        end
      end
      arcd_pkg::ARCD_DELAY: begin
        if (delay_expire) begin
          nxt_state = arcd_pkg::ARCD_CONV;
        end
      end
      arcd_pkg::ARCD_CONV: begin
        if (adc_rsp.done) begin
          nxt_state = arcd_pkg::ARCD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= arcd_pkg::ARCD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Brake request: level while compare holds, run clear on its rise
  assign brake_lvl = brake_en_ff && cmp_en_ff && cmp_out_ff;
  assign brake_rise = brake_lvl && !brake_prev_ff;
  assign pwm_req.brake = brake_lvl;
  assign pwm_req.run_clr = brake_rise;
  assign irq = |(irq_stat_ff & irq_mask_ff);
  assign pin_dread = pin_dread_ff;

  // Software-visible registers and flags
  always_comb begin
    nxt_result = result_ff;
    nxt_cmp_value = cmp_value_ff;
    nxt_brake_en = brake_en_ff;
    nxt_polarity = polarity_ff;
    nxt_cmp_en = cmp_en_ff;
    nxt_cmp_out = cmp_out_ff;
    nxt_delay = delay_ff;
    nxt_disconnect = disconnect_ff;
    nxt_ext_en = ext_en_ff;
    nxt_done = done_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_en) begin
      unique case (idx[7:0])
        `ARCD_IDX_CMP_LOW: nxt_cmp_value[3:0] = wbyte[3:0];
        `ARCD_IDX_CMP_HIGH: nxt_cmp_value[11:4] = wbyte;
        `ARCD_IDX_CMP_BRAKE_CTRL: begin
          nxt_brake_en = wbyte[`ARCD_CBC_BRAKE_EN];
          nxt_polarity = wbyte[`ARCD_CBC_POLARITY];
          nxt_cmp_en = wbyte[`ARCD_CBC_CMP_EN];
          nxt_delay[8] = wbyte[`ARCD_CBC_DELAY_B8];
        end
        `ARCD_IDX_TRIG_DELAY_LOW: nxt_delay[7:0] = wbyte;
        `ARCD_IDX_PIN_DISCONNECT: nxt_disconnect = wbyte;
        `ARCD_IDX_CONV_CTRL: begin
          nxt_ext_en = wbyte[`ARCD_CC_EXT_TRIG_EN];
          if (!wbyte[`ARCD_CC_DONE_FLAG]) begin
            nxt_done = 1'b0;
          end
        end
        `ARCD_IDX_IRQ_STATUS: nxt_irq_stat = irq_stat_ff & ~wbyte[1:0];
        `ARCD_IDX_IRQ_MASK: nxt_irq_mask = wbyte[1:0];
        default: begin
        end
      endcase
    end
    // Disabled comparator reports no match, except for one cycle when the disable write meets a conversion end
    if (!nxt_cmp_en) begin
      nxt_cmp_out = 1'b0;
    end
    // Completion wins over a same-cycle software clear
    if (conv_end) begin
      nxt_result = adc_rsp.data;
      nxt_done = 1'b1;
      nxt_irq_stat[`ARCD_IRQ_DONE] = 1'b1;
      if (cmp_en_ff) begin
        nxt_cmp_out = compare(adc_rsp.data, cmp_value_ff, polarity_ff);
      end
    end
    if (brake_rise) begin
      nxt_irq_stat[`ARCD_IRQ_BRAKE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= `ARCD_RST_CMP;
      cmp_value_ff <= `ARCD_RST_CMP;
      brake_en_ff <= 1'b0;
      polarity_ff <= 1'b0;
      cmp_en_ff <= 1'b0;
      cmp_out_ff <= 1'b0;
      delay_ff <= `ARCD_RST_DELAY;
      disconnect_ff <= `ARCD_RST_BYTE;
      ext_en_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_stat_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
    end else begin
      result_ff <= nxt_result;
      cmp_value_ff <= nxt_cmp_value;
      brake_en_ff <= nxt_brake_en;
      polarity_ff <= nxt_polarity;
      cmp_en_ff <= nxt_cmp_en;
      cmp_out_ff <= nxt_cmp_out;
      delay_ff <= nxt_delay;
      disconnect_ff <= nxt_disconnect;
      ext_en_ff <= nxt_ext_en;
      done_ff <= nxt_done;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Read mux, sampled in the setup phase
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_setup) begin
      nxt_rdata = 32'h0000_0000;
      unique case (idx[7:0])
        `ARCD_IDX_RESULT_LOW: nxt_rdata[3:0] = result_ff[3:0];
        `ARCD_IDX_RESULT_HIGH: nxt_rdata[7:0] = result_ff[11:4];
        `ARCD_IDX_CMP_LOW: nxt_rdata[3:0] = cmp_value_ff[3:0];
        `ARCD_IDX_CMP_HIGH: nxt_rdata[7:0] = cmp_value_ff[11:4];
        `ARCD_IDX_CMP_BRAKE_CTRL: begin
          nxt_rdata[`ARCD_CBC_BRAKE_EN] = brake_en_ff;
          nxt_rdata[`ARCD_CBC_POLARITY] = polarity_ff;
          nxt_rdata[`ARCD_CBC_CMP_EN] = cmp_en_ff;
          nxt_rdata[`ARCD_CBC_CMP_OUT] = cmp_out_ff;
          nxt_rdata[`ARCD_CBC_DELAY_B8] = delay_ff[8];
        end
        `ARCD_IDX_TRIG_DELAY_LOW: nxt_rdata[7:0] = delay_ff[7:0];
        `ARCD_IDX_PIN_DISCONNECT: nxt_rdata[7:0] = disconnect_ff;
        `ARCD_IDX_CONV_CTRL: begin
          nxt_rdata[`ARCD_CC_EXT_TRIG_EN] = ext_en_ff;
          nxt_rdata[`ARCD_CC_START_BUSY] = (state_ff != arcd_pkg::ARCD_IDLE);
          nxt_rdata[`ARCD_CC_DONE_FLAG] = done_ff;
        end
        `ARCD_IDX_IRQ_STATUS: nxt_rdata[1:0] = irq_stat_ff;
        `ARCD_IDX_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
        default: begin
        end
      endcase
      if (idx[8]) begin
        nxt_rdata = 32'h0000_0000; // Misaligned reads return zero
      end
    end
  end

  // Pin read path; first sync flop feeds only the second
  always_comb begin
    nxt_pin_dread = pin_sync_ff & ~disconnect_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
      pin_meta_ff <= `ARCD_RST_BYTE;
      pin_sync_ff <= `ARCD_RST_BYTE;
      pin_dread_ff <= `ARCD_RST_BYTE;
      brake_prev_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      trig_meta_ff <= ext_trigger;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
      pin_meta_ff <= pin_din;
      pin_sync_ff <= pin_meta_ff;
      pin_dread_ff <= nxt_pin_dread;
      brake_prev_ff <= brake_lvl;
    end
  end

endmodule

// File: test/arcd_core_properties.sv
`timescale 1ns/1ps
module arcd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire arcd_pkg::arcd_adc_rsp_t adc_rsp,
  input wire logic adc_start,
  input wire arcd_pkg::arcd_pwm_req_t pwm_req,
  input wire logic [7:0] pin_din,
  input wire logic [7:0] pin_dread,
  input wire logic irq
);
  logic pend_ff;
  logic nxt_pend;
  wire logic wr = psel && penable && pwrite;
  // Conversion in flight from start until done
  always_comb begin
    nxt_pend = pend_ff;
    if (adc_start) nxt_pend = 1'b1;
    if (adc_rsp.done) nxt_pend = 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_ff <= 1'b0;
    else pend_ff <= nxt_pend;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata moved");
  a_start_busy: assert property (adc_start |-> !pend_ff) else $error("start while busy");
  a_clr_on_rise: assert property ($rose(pwm_req.brake) |-> pwm_req.run_clr)
    else $error("no run clear");
  a_clr_pulse: assert property (pwm_req.run_clr |-> pwm_req.brake ##1 !pwm_req.run_clr)
    else $error("run clear not a pulse");
  a_brake_rise: assert property ($rose(pwm_req.brake) |-> $past(adc_rsp.done) || $past(wr))
    else $error("brake rose without cause");
  a_brake_fall: assert property ($fell(pwm_req.brake) |-> $past(adc_rsp.done) || $past(wr))
    else $error("brake fell without cause");
  a_pin_mask: assert property ((pin_dread & ~$past(pin_din, 3)) == 8'h00)
    else $error("pin read set without input");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr)) else $error("irq fell alone");
endmodule
bind arcd_core arcd_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_rsp(adc_rsp), .adc_start(adc_start), .pwm_req(pwm_req), .pin_din(pin_din),
  .pin_dread(pin_dread), .irq(irq));

// File: test/arcd_adc_model.sv
`timescale 1ns/1ps
module arcd_adc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_start,
  input wire logic [3:0] lat,
  input wire logic [11:0] val,
  output arcd_pkg::arcd_adc_rsp_t adc_rsp
);
  logic [3:0] cnt_ff;
  logic [11:0] res_ff;
  // Count out the conversion, lat must be at least 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      res_ff <= 12'h000;
    end else if (adc_start) begin
      cnt_ff <= lat;
      res_ff <= val;
    end else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
  end
  // Data only good with done; inverse elsewhere so stale reads show
  assign adc_rsp.done = (cnt_ff == 4'h1);
  assign adc_rsp.data = adc_rsp.done ? res_ff : ~res_ff;
endmodule

// File: test/arcd_core_test.sv
`timescale 1ns/1ps
module arcd_core_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_trigger = 1'b0, pready, pslverr, adc_start, irq, err, o, pol, ce, be;
  logic [11:0] paddr = 12'h000, val = 12'h000, r, c;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] pin_din = 8'h00, pin_dread, d;
  logic [7:0] ids [7] = '{8'hC2, 8'hC3, 8'hCE, 8'hCF, 8'hE2, 8'hE3, 8'hF6};
  logic [8:0] dl [5] = '{9'h000, 9'h001, 9'h0FF, 9'h100, 9'h1FF};
  logic [3:0] lat = 4'h3;
  logic [1:0] m;
  arcd_pkg::arcd_adc_rsp_t adc_rsp;
  arcd_pkg::arcd_pwm_req_t pwm_req;
  int error_cnt = 0, tests_run = 0, starts = 0, clrs = 0, n0, k0, t, off;
  arcd_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trigger(ext_trigger), .adc_rsp(adc_rsp), .adc_start(adc_start),
    .pwm_req(pwm_req), .pin_din(pin_din), .pin_dread(pin_dread), .irq(irq));
  arcd_adc_model adc_u (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .lat(lat),
    .val(val), .adc_rsp(adc_rsp));
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Count start and run clear pulses
  always @(posedge pclk) begin
    starts <= starts + adc_start;
    clrs <= clrs + pwm_req.run_clr;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; byte address is index times four
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic cmp_f(logic [11:0] rv, logic [11:0] cv, logic p, logic e);
    return e && (p ? rv < cv : rv >= cv);
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h5944));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ids[i]) begin
      apb(1'b0, ids[i], 0);
      chk("reset value", rd, 0);
    end
    apb(1'b1, 8'hC3, 32'hFF);
    apb(1'b0, 8'hC3, 0);
    chk("result ro", rd, 0);
    apb(1'b0, 8'hC4, 0);
    chk("unmapped err", err, 1);
    // Comparator, brake and interrupt; first two hit the equal and one-below edges
    for (int i = 0; i < 16; i++) begin
      c = $urandom();
      r = (i < 2) ? c - i[11:0] : $urandom();
      {pol, be, m} = $urandom();
      ce = (i % 4 != 3);
      o = cmp_f(r, c, pol, ce);
      apb(1'b1, 8'hE2, 0);
      apb(1'b1, 8'hCE, c[3:0]);
      apb(1'b1, 8'hCF, c[11:4]);
      apb(1'b0, 8'hCF, 0);
      chk("cmp high", rd, c[11:4]);
      apb(1'b1, 8'hE2, {be, pol, ce, 5'h00});
      apb(1'b1, 8'hEB, m);
      val <= r;
      lat <= 4'(3 + $urandom_range(12));
      n0 = starts;
      k0 = clrs;
      apb(1'b1, 8'hE8, 2);
      apb(1'b0, 8'hE8, 0);
      chk("busy", rd[1], 1);
      for (int k = 0; k < 20 && !rd[2]; k++) apb(1'b0, 8'hE8, 0);
      chk("done flag", rd[2], 1);
      chk("self clear", rd[1], 0);
      apb(1'b1, 8'hE8, 2);
      apb(1'b0, 8'hC3, 0);
      chk("result high", rd, r[11:4]);
      apb(1'b0, 8'hC2, 0);
      chk("result low", rd, r[3:0]);
      apb(1'b1, 8'hCF, ~c[11:4]);
      apb(1'b0, 8'hE2, 0);
      chk("compare out", rd[4], o);
      chk("blocked start", starts - n0, 1);
      chk("brake", pwm_req.brake, be && o);
      chk("run clear", clrs - k0, be && o);
      chk("irq", irq, m[0] | (m[1] & be & o));
      apb(1'b1, 8'hE8, 0);
      apb(1'b1, 8'hEA, 3);
      // Clear lands on that edge; look once it has settled
      @(negedge pclk);
      chk("irq clear", irq, 0);
    end
    // External trigger delay, with a second trigger while busy
    lat <= 4'hF;
    foreach (dl[j]) begin
      apb(1'b1, 8'hE3, dl[j][7:0]);
      apb(1'b1, 8'hE2, {7'h00, dl[j][8]});
      apb(1'b1, 8'hE8, 1);
      n0 = starts;
      t = 0;
      ext_trigger <= 1'b1;
      do begin
        @(posedge pclk);
        t++;
      end while (adc_start !== 1'b1 && t < 600);
      if (j == 0) off = t;
      if (j == 0) chk("zero delay", off, 4);
      chk("start delay", t - off, dl[j]);
      ext_trigger <= 1'b0;
      repeat (3) @(posedge pclk);
      ext_trigger <= 1'b1;
      repeat (20) @(posedge pclk);
      ext_trigger <= 1'b0;
      chk("busy trigger", starts - n0, 1);
      apb(1'b1, 8'hE8, 0);
      apb(1'b1, 8'hEA, 3);
    end
    // Digital input disconnect
    repeat (8) begin
      d = $urandom();
      apb(1'b1, 8'hF6, d);
      pin_din <= $urandom();
      repeat (5) @(posedge pclk);
      chk("pin read", pin_dread, pin_din & ~d);
    end
    end_sim();
  end
endmodule
